/* File: include/tfs_pkg.sv */
// Constants and types of the table access and flash self-program unit
`default_nettype none
package tfs_pkg;
  // Widths and sizes
  localparam int unsigned PTR_W      = 22;
  localparam int unsigned LOW_W      = 21;
  localparam int unsigned HOLD_N     = 16;
  localparam int unsigned HOLD_SEL_W = 4;
  localparam int unsigned ROW_LSB    = 6;
  localparam int unsigned BLK_LSB    = 4;
  localparam int unsigned TIMER_W    = 20;
  // Special register selects
  localparam logic [2:0] SEL_LATCH  = 3'h0;
  localparam logic [2:0] SEL_UPPER  = 3'h1;
  localparam logic [2:0] SEL_HIGH   = 3'h2;
  localparam logic [2:0] SEL_LOW    = 3'h3;
  localparam logic [2:0] SEL_CTRL   = 3'h4;
  localparam logic [2:0] SEL_UNLOCK = 3'h5;
  // Bit positions in memory_control_one
  localparam int unsigned B_CONFIG_SPACE_SELECT  = 6;
  localparam int unsigned B_ERASE = 4;
  localparam int unsigned B_WRITE_ERROR_FLAG = 3;
  localparam int unsigned B_WRITE_ENABLE_BIT  = 2;
  localparam int unsigned B_WR    = 1;
  // Unlock keys and erased byte
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  // Unlock progress
  localparam logic [1:0] UNL_NONE  = 2'h0;
  localparam logic [1:0] UNL_FIRST = 2'h1;
  localparam logic [1:0] UNL_READY = 2'h2;
  // Pointer modes of a table operation
  localparam logic [1:0] MODE_KEEP     = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_INC  = 2'h3;
  // Long write time
  localparam int unsigned LONG_WRITE_NS = 2000000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned LONG_WRITE_CYCLES = LONG_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LONG} tfs_state_t;
endpackage : tfs_pkg
`default_nettype wire

/* File: hdl/tfs_self_prog.sv */
// Table latch, table pointer, holding registers and long write sequencer
`timescale 1ns/1ns
`default_nettype none
module tfs_self_prog #(
  parameter int unsigned PROG_CYCLES = tfs_pkg::LONG_WRITE_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         sfr_we,
  input  wire logic [2:0]   sfr_sel,
  input  wire logic [7:0]   sfr_wdata,
  output var  logic [7:0]   sfr_rdata,
  input  wire logic         tbl_req,
  input  wire logic         tbl_write,
  input  wire logic [1:0]   tbl_mode,
  output var  logic         tbl_done,
  output var  logic         mem_rd_en,
  output var  logic [21:0]  mem_addr,
  input  wire logic [7:0]   mem_rd_data,
  output var  logic         mem_erase,
  output var  logic         mem_prog,
  output var  logic         mem_cfg,
  output var  logic [127:0] mem_wdata,
  output var  logic         cpu_stall
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tfs_pkg::tfs_state_t  fsm;
    logic [7:0]           latch;
    logic [21:0]          ptr;
    logic                 config_space_select;
    logic                 erase_sel;
    logic                 write_error_flag;
    logic                 write_enable_bit;
    logic                 wr;
    logic [1:0]           unlock;
    logic [15:0][7:0]     hold;
    logic [19:0]          timer;
    logic                 is_erase;
    logic [7:0]           rdata;
    logic                 done;
    logic                 rd_en;
    logic [21:0]          addr;
    logic                 erase;
    logic                 prog;
    logic                 cfg_out;
    logic                 stall;
  } tfs_regs_t;

  tfs_regs_t s_q;
  tfs_regs_t s_d;

  logic [21:0] ptr_pre;
  logic [21:0] ptr_post;
  logic        start_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d   = s_q;
    s_d.done  = 1'b0;
    s_d.rd_en = 1'b0;
    s_d.erase = 1'b0;
    s_d.prog  = 1'b0;
    ptr_pre  = s_q.ptr;
    if (tbl_mode == tfs_pkg::MODE_PRE_INC)
    begin
      ptr_pre[20:0] = s_q.ptr[20:0] + 21'h000001;
    end
    ptr_post = ptr_pre;
    if (tbl_mode == tfs_pkg::MODE_POST_INC)
    begin
      ptr_post[20:0] = s_q.ptr[20:0] + 21'h000001;
    end
    else if (tbl_mode == tfs_pkg::MODE_POST_DEC)
    begin
      ptr_post[20:0] = s_q.ptr[20:0] - 21'h000001;
    end
    start_ok = sfr_we && sfr_sel == tfs_pkg::SEL_CTRL && sfr_wdata[tfs_pkg::B_WR]
               && s_q.unlock == tfs_pkg::UNL_READY;

    unique case (s_q.fsm)
      tfs_pkg::ST_IDLE:
      begin
        if (tbl_req)
        begin
          s_d.ptr    = ptr_post;
          s_d.unlock = tfs_pkg::UNL_NONE;
          if (tbl_write)
          begin
            s_d.hold[ptr_pre[3:0]] = s_q.latch;
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.rd_en = 1'b1;
            s_d.addr  = ptr_pre;
            s_d.fsm   = tfs_pkg::ST_READ;
          end
        end
        else if (sfr_we)
        begin
          s_d.unlock = tfs_pkg::UNL_NONE;
          unique case (sfr_sel)
            tfs_pkg::SEL_LATCH: s_d.latch = sfr_wdata;
            tfs_pkg::SEL_UPPER: s_d.ptr[21:16] = sfr_wdata[5:0];
            tfs_pkg::SEL_HIGH:  s_d.ptr[15:8]  = sfr_wdata;
            tfs_pkg::SEL_LOW:   s_d.ptr[7:0]   = sfr_wdata;
            tfs_pkg::SEL_UNLOCK:
            begin
              if (sfr_wdata == tfs_pkg::KEY_FIRST)
              begin
                s_d.unlock = tfs_pkg::UNL_FIRST;
              end
              else if (sfr_wdata == tfs_pkg::KEY_SECOND
                       && s_q.unlock == tfs_pkg::UNL_FIRST)
              begin
                s_d.unlock = tfs_pkg::UNL_READY;
              end
            end
            tfs_pkg::SEL_CTRL:
            begin
              s_d.config_space_select      = sfr_wdata[tfs_pkg::B_CONFIG_SPACE_SELECT];
              s_d.erase_sel = sfr_wdata[tfs_pkg::B_ERASE];
              s_d.write_error_flag     = sfr_wdata[tfs_pkg::B_WRITE_ERROR_FLAG];
              s_d.write_enable_bit      = sfr_wdata[tfs_pkg::B_WRITE_ENABLE_BIT];
              if (start_ok && sfr_wdata[tfs_pkg::B_WRITE_ENABLE_BIT])
              begin
                s_d.wr       = 1'b1;
                s_d.stall    = 1'b1;
                s_d.fsm      = tfs_pkg::ST_LONG;
                s_d.timer    = PROG_CYCLES[19:0] - 20'h00001;
                s_d.is_erase = sfr_wdata[tfs_pkg::B_ERASE];
                s_d.cfg_out  = sfr_wdata[tfs_pkg::B_CONFIG_SPACE_SELECT];
                if (sfr_wdata[tfs_pkg::B_ERASE])
                begin
                  s_d.erase = 1'b1;
                  s_d.addr  = {s_q.ptr[21:6], 6'h00};
                end
                else
                begin
                  s_d.prog = 1'b1;
                  s_d.addr = {s_q.ptr[21:4], 4'h0};
                end
              end
            end
            default: s_d.unlock = tfs_pkg::UNL_NONE;
          endcase
        end
      end
      tfs_pkg::ST_READ:
      begin
        s_d.latch = mem_rd_data;
        s_d.done  = 1'b1;
        s_d.fsm   = tfs_pkg::ST_IDLE;
      end
      tfs_pkg::ST_LONG:
      begin
        s_d.timer = s_q.timer - 20'h00001;
        if (s_q.timer == 20'h00000)
        begin
          s_d.fsm   = tfs_pkg::ST_IDLE;
          s_d.stall = 1'b0;
          s_d.wr    = 1'b0;
          if (s_q.is_erase)
          begin
            s_d.erase_sel = 1'b0;
          end
          else
          begin
            for (int i = 0; i < 16; i++)
            begin
              s_d.hold[i] = tfs_pkg::BYTE_ERASED;
            end
          end
        end
      end
      default: s_d.fsm = tfs_pkg::ST_IDLE;
    endcase

    // Registered special register read
    unique case (sfr_sel)
      tfs_pkg::SEL_LATCH: s_d.rdata = s_q.latch;
      tfs_pkg::SEL_UPPER: s_d.rdata = {2'h0, s_q.ptr[21:16]};
      tfs_pkg::SEL_HIGH:  s_d.rdata = s_q.ptr[15:8];
      tfs_pkg::SEL_LOW:   s_d.rdata = s_q.ptr[7:0];
      tfs_pkg::SEL_CTRL:  s_d.rdata = {1'b0, s_q.config_space_select, 1'b0, s_q.erase_sel, s_q.write_error_flag,
                                       s_q.write_enable_bit, s_q.wr, 1'b0};
      default:            s_d.rdata = tfs_pkg::BYTE_ZERO;
    endcase

    if (srst)
    begin
      // early end flagged, config select kept only on early end and cleared otherwise
      s_d.write_error_flag = (s_q.fsm == tfs_pkg::ST_LONG);
      s_d.config_space_select  = (s_q.fsm == tfs_pkg::ST_LONG) ? s_q.config_space_select : 1'b0;
      s_d.fsm   = tfs_pkg::ST_IDLE;
      s_d.latch = tfs_pkg::BYTE_ZERO;
      s_d.ptr   = 22'h000000;
      s_d.erase_sel = 1'b0;
      s_d.write_enable_bit  = 1'b0;
      s_d.wr    = 1'b0;
      s_d.unlock = tfs_pkg::UNL_NONE;
      for (int i = 0; i < 16; i++)
      begin
        s_d.hold[i] = tfs_pkg::BYTE_ERASED;
      end
      s_d.timer    = 20'h00000;
      s_d.is_erase = 1'b0;
      s_d.rdata    = tfs_pkg::BYTE_ZERO;
      s_d.done     = 1'b0;
      s_d.rd_en    = 1'b0;
      s_d.addr     = 22'h000000;
      s_d.erase    = 1'b0;
      s_d.prog     = 1'b0;
      s_d.cfg_out  = 1'b0;
      s_d.stall    = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  assign sfr_rdata = s_q.rdata;
  assign tbl_done  = s_q.done;
  assign mem_rd_en = s_q.rd_en;
  assign mem_addr  = s_q.addr;
  assign mem_erase = s_q.erase;
  assign mem_prog  = s_q.prog;
  assign mem_cfg   = s_q.cfg_out;
  assign mem_wdata = s_q.hold;
  assign cpu_stall = s_q.stall;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence long_start_s;
    mem_erase || mem_prog;
  endsequence

  sequence unlocked_ctrl_s;
    sfr_we && sfr_sel == tfs_pkg::SEL_CTRL && s_q.unlock == tfs_pkg::UNL_READY;
  endsequence

  a_ptr_top_kept: assert property (@(posedge clk) disable iff (srst)
    tbl_req && s_q.fsm == tfs_pkg::ST_IDLE |=> s_q.ptr[21] == $past(s_q.ptr[21]))
    else $error("auto update changed pointer top bit");

  a_read_fills_latch: assert property (@(posedge clk) disable iff (srst)
    mem_rd_en |=> tbl_done && s_q.latch == $past(mem_rd_data))
    else $error("table read did not fill latch");

  a_erase_row_align: assert property (@(posedge clk) disable iff (srst)
    mem_erase |-> mem_addr[5:0] == 6'h00 && cpu_stall)
    else $error("erase address not row aligned");

  a_prog_block_align: assert property (@(posedge clk) disable iff (srst)
    mem_prog |-> mem_addr[3:0] == 4'h0 && !mem_erase)
    else $error("program address not block aligned");

  a_start_unlocked: assert property (@(posedge clk) disable iff (srst)
    long_start_s |-> $past(s_q.unlock) == tfs_pkg::UNL_READY)
    else $error("long write started without unlock");

  a_erase_write_enable_bit: assert property (@(posedge clk) disable iff (srst)
    mem_erase |-> s_q.write_enable_bit && s_q.erase_sel)
    else $error("erase without enables");

  a_stall_holds: assert property (@(posedge clk) disable iff (srst)
    unlocked_ctrl_s ##1 long_start_s |-> cpu_stall [*8])
    else $error("core not stalled during long write");

  a_end_clears: assert property (@(posedge clk) disable iff (srst)
    $fell(cpu_stall) |-> !s_q.wr && !s_q.erase_sel)
    else $error("start or erase select left set at end");

  a_hold_erased: assert property (@(posedge clk) disable iff (srst)
    $fell(cpu_stall) && !s_q.is_erase |-> &s_q.hold)
    else $error("holding registers not restored");

  a_no_start_locked: assert property (@(posedge clk) disable iff (srst)
    s_q.unlock != tfs_pkg::UNL_READY && s_q.fsm == tfs_pkg::ST_IDLE |=> !long_start_s)
    else $error("start accepted with broken unlock");

endmodule : tfs_self_prog
`default_nettype wire

/* File: testbench/tfs_flash_model.sv */
// Behavioural flash array facing the self-program unit
`timescale 1ns/1ns
`default_nettype none
module tfs_flash_model (
  input  wire logic         clk,
  input  wire logic [21:0]  mem_addr,
  input  wire logic         mem_erase,
  input  wire logic         mem_prog,
  input  wire logic         mem_cfg,
  input  wire logic [127:0] mem_wdata,
  output var  logic [7:0]   mem_rd_data
);
  logic [7:0] arr [256];
  initial
  begin
    for (int i = 0; i < 256; i++)
      arr[i] = 8'(i) ^ 8'h5A;
  end
  assign mem_rd_data = mem_addr[21] ? (mem_addr[7:0] ^ 8'hC3) : arr[mem_addr[7:0]];
  always @(posedge clk)
  begin
    if (mem_erase === 1'b1 && mem_cfg === 1'b0)
      for (int i = 0; i < 64; i++)
        arr[{mem_addr[7:6], 6'(i)}] = 8'hFF;
    if (mem_prog === 1'b1 && mem_cfg === 1'b0)
      for (int i = 0; i < 16; i++)
        arr[{mem_addr[7:4], 4'(i)}] &= mem_wdata[8*i +: 8];
  end
endmodule : tfs_flash_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the table access and flash self-program unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int unsigned PROG = 20;
  logic         clk, srst, sfr_we, tbl_req, tbl_write;
  logic [2:0]   sfr_sel;
  logic [7:0]   sfr_wdata, sfr_rdata, mem_rd_data, rd;
  logic [1:0]   tbl_mode;
  logic         tbl_done, mem_rd_en, mem_erase, mem_prog, mem_cfg, cpu_stall;
  logic [21:0]  mem_addr, rd_addr;
  logic [127:0] mem_wdata;
  int           bad_count = 0;
  int           n_compared = 0;
  int           n_ops = 0;
  int           n;

  tfs_self_prog #(.PROG_CYCLES(PROG)) tfs_self_prog_inst (.clk, .srst, .sfr_we, .sfr_sel,
    .sfr_wdata, .sfr_rdata, .tbl_req, .tbl_write, .tbl_mode, .tbl_done, .mem_rd_en,
    .mem_addr, .mem_rd_data, .mem_erase, .mem_prog, .mem_cfg, .mem_wdata, .cpu_stall);
  tfs_flash_model tfs_flash_model_inst (.clk, .mem_addr, .mem_erase, .mem_prog, .mem_cfg,
    .mem_wdata, .mem_rd_data);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (mem_erase === 1'b1 || mem_prog === 1'b1) n_ops++;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    sfr_we = 1'b1;
    sfr_sel = s;
    sfr_wdata = d;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask : wr
  task automatic rdr(input logic [2:0] s);
    @(negedge clk);
    sfr_sel = s;
    @(negedge clk);
    rd = sfr_rdata;
  endtask : rdr
  task automatic setp(input logic [21:0] p);
    wr(3'h1, {2'h0, p[21:16]});
    wr(3'h2, p[15:8]);
    wr(3'h3, p[7:0]);
  endtask : setp
  // Unlock keys, then control write; returns while the start pulse stands
  task automatic start(input logic [7:0] c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c);
  endtask : start
  task automatic tbl(input logic w, input logic [1:0] m);
    @(negedge clk);
    tbl_req = 1'b1;
    tbl_write = w;
    tbl_mode = m;
    @(negedge clk);
    tbl_req = 1'b0;
    for (int i = 0; i < 4 && tbl_done !== 1'b1; i++)
    begin
      if (mem_rd_en === 1'b1) rd_addr = mem_addr;
      @(negedge clk);
    end
    chk(tbl_done, 1'b1);
  endtask : tbl
  task automatic wait_idle;
    n = 0;
    while (cpu_stall === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge clk);
    end
  endtask : wait_idle

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int s = 0; s < 8; s++)
    begin
      rdr(3'(s));
      chk(rd, 8'h00);
    end
    chk(&mem_wdata, 1'b1);
    chk(cpu_stall, 1'b0);
  endtask : t_reset
  task automatic t_modes;
    setp(22'h3FFFFF);
    tbl(1'b0, tfs_pkg::MODE_POST_INC);
    chk(rd_addr, 22'h3FFFFF);
    rdr(3'h0);
    chk(rd, 8'h3C);
    rdr(3'h1);
    chk(rd, 8'h20);
    tbl(1'b0, tfs_pkg::MODE_PRE_INC);
    chk(rd_addr, 22'h200001);
    rdr(3'h0);
    chk(rd, 8'hC2);
    tbl(1'b0, tfs_pkg::MODE_POST_DEC);
    tbl(1'b0, tfs_pkg::MODE_POST_DEC);
    chk(rd_addr, 22'h200000);
    rdr(3'h1);
    chk(rd, 8'h3F);
    tbl(1'b0, tfs_pkg::MODE_KEEP);
    chk(rd_addr, 22'h3FFFFF);
    rdr(3'h3);
    chk(rd, 8'hFF);
  endtask : t_modes
  task automatic t_prog;
    setp(22'h000013);
    wr(3'h0, 8'h1A);
    tbl(1'b1, tfs_pkg::MODE_POST_INC);
    chk(mem_wdata[31:24], 8'h1A);
    wr(3'h0, 8'h34);
    tbl(1'b1, tfs_pkg::MODE_POST_INC);
    chk(mem_wdata[39:32], 8'h34);
    start(8'h06);
    chk({mem_prog, mem_erase, mem_cfg, cpu_stall}, 4'h9);
    chk(mem_addr, 22'h000010);
    wait_idle;
    chk(n, PROG);
    chk(&mem_wdata, 1'b1);
    rdr(3'h4);
    chk(rd, 8'h04);
    rdr(3'h3);
    chk(rd, 8'h15);
    rdr(3'h0);
    chk(rd, 8'h34);
    setp(22'h000013);
    tbl(1'b0, tfs_pkg::MODE_KEEP);
    rdr(3'h0);
    chk(rd, 8'h08);
    tbl(1'b0, tfs_pkg::MODE_PRE_INC);
    rdr(3'h0);
    chk(rd, 8'h04);
    tbl(1'b0, tfs_pkg::MODE_PRE_INC);
    rdr(3'h0);
    chk(rd, 8'h4F);
  endtask : t_prog
  task automatic t_erase;
    setp(22'h00007F);
    start(8'h16);
    chk({mem_erase, mem_prog, cpu_stall}, 3'h5);
    chk(mem_addr, 22'h000040);
    wait_idle;
    chk(n, PROG);
    rdr(3'h4);
    chk(rd, 8'h04);
    tbl(1'b0, tfs_pkg::MODE_KEEP);
    rdr(3'h0);
    chk(rd, 8'hFF);
  endtask : t_erase
  task automatic t_refuse;
    int k;
    k = n_ops;
    wr(3'h5, 8'h55);
    wr(3'h0, 8'h00);
    wr(3'h5, 8'hAA);
    wr(3'h4, 8'h06);
    repeat (3) @(negedge clk);
    chk(n_ops, k);
    start(8'h12);
    chk(cpu_stall, 1'b0);
    rdr(3'h4);
    chk(rd, 8'h10);
    chk(n_ops, k);
    wr(3'h4, 8'h00);
  endtask : t_refuse
  task automatic t_cfg_reset;
    wr(3'h0, 8'h00);
    tbl(1'b1, tfs_pkg::MODE_KEEP);
    chk(mem_wdata[127:120], 8'h00);
    start(8'h46);
    chk({mem_cfg, cpu_stall}, 2'h3);
    repeat (3) @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk(cpu_stall, 1'b0);
    rdr(3'h4);
    chk(rd, 8'h48);
    chk(&mem_wdata, 1'b1);
  endtask : t_cfg_reset

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #40000;
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    srst = 1'b1;
    sfr_we = 1'b0;
    sfr_sel = 3'h0;
    sfr_wdata = 8'h00;
    tbl_req = 1'b0;
    tbl_write = 1'b0;
    tbl_mode = 2'h0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_reset;
    t_modes;
    t_prog;
    t_erase;
    t_refuse;
    t_cfg_reset;
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
